// ### include/srm_defs.svh
// Register map, field positions and reset values of the stream rate and self-test bank.
// Assumes a 14-bit word address and 16-bit data on the parallel host port.
`ifndef SRM_DEFS_SVH
`define SRM_DEFS_SVH
`define SRM_AW              14
`define SRM_DW              16
`define SRM_NSTREAM         16
`define SRM_LOR_BASE        14'h00ED
`define SRM_BIR_BASE        14'h010D
`define SRM_BOR_BASE        14'h012D
`define SRM_MST_ADDR        14'h014D
`define SRM_ID_ADDR         14'h3FFF
`define SRM_RATE_RESET      2'h0
`define SRM_FAST_LAST       4'h7
`define SRM_ST_ENABLE_BIT   12
`define SRM_ST_START_BD     11
`define SRM_ST_START_LD     8
`define SRM_ST_START_BC     5
`define SRM_ST_START_LC     2
`define SRM_RATE_FIELD      1:0
`define SRM_ID_REV_DEFAULT  4'h5
`define SRM_ID_DEV_DEFAULT  3'h5
`define SRM_MEM_CYCLES      12'h400
`endif

// ### include/srm_pkg.sv
// Types shared by the rate/self-test register bank and its memory test engine.
// Assumes srm_defs.svh is on the include path.
package srm_pkg;
    typedef enum logic [2:0] {SRM_RATE_2M, SRM_RATE_4M, SRM_RATE_8M, SRM_RATE_16M,
                              SRM_RATE_32M, SRM_RATE_OFF} srm_rate_t;
    typedef enum logic [1:0] {SRM_T_IDLE, SRM_T_RUN, SRM_T_DONE} srm_tstate_t;
endpackage

// ### include/srm_test_if.sv
// Start, done and pass signals of the four memory test engines.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface srm_test_if;
    logic [3:0] start;
    logic [3:0] enable;
    logic [3:0] done;
    logic [3:0] pass;
    logic [3:0] fault;
    modport ctrl (output start, output enable, output fault, input done, input pass);
    modport eng  (input start, input enable, input fault, output done, output pass);
endinterface

// ### design/srm_test_engine.sv
// Four memory test sequencers, one per memory, started by a pulse.
// Assumes start pulses come from the register bank on the same clock.
`timescale 1ns/10ps
`include "srm_defs.svh"
module srm_test_engine
    import srm_pkg::*;
(
    input  wire logic  i_mclk,
    input  wire logic  i_reset,
    srm_test_if.eng    tif
);
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_mem
            srm_tstate_t st;
            logic [11:0] cnt;
            always_ff @(posedge i_mclk) begin
                if (i_reset || !tif.enable[g]) begin
                    st <= SRM_T_IDLE;
                end else if (tif.start[g]) begin
                    st <= SRM_T_RUN;
                end else if (st == SRM_T_RUN && cnt == `SRM_MEM_CYCLES - 12'h001) begin
                    st <= SRM_T_DONE;
                end
            end
            always_ff @(posedge i_mclk) begin
                if (i_reset || tif.start[g] || st != SRM_T_RUN) begin
                    cnt <= 12'h000;
                end else begin
                    cnt <= cnt + 12'h001;
                end
            end
            // Pass latched at the last sweep step; a fault input models a failing array
            always_ff @(posedge i_mclk) begin
                if (i_reset || !tif.enable[g] || tif.start[g]) begin
                    tif.pass[g] <= 1'b0;
                end else if (st == SRM_T_RUN && cnt == `SRM_MEM_CYCLES - 12'h001) begin
                    tif.pass[g] <= !tif.fault[g];
                end
            end
            assign tif.done[g] = (st == SRM_T_DONE);
        end
    endgenerate
endmodule

// ### design/srm_regs.sv
// Stream rate registers, memory self-test register and identity register.
// Assumes a synchronous host port on i_mclk; read data is registered, one cycle.
`timescale 1ns/10ps
`include "srm_defs.svh"
module srm_regs
    import srm_pkg::*;
#(
    parameter logic [3:0] REV_CODE = `SRM_ID_REV_DEFAULT,  // Arbitrary value
    parameter logic [2:0] DEV_CODE = `SRM_ID_DEV_DEFAULT   // Arbitrary value
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_reset,
    input  wire logic [13:0]       i_addr,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_local_fast_mode,
    input  wire logic              i_backplane_fast_mode,
    input  wire logic [3:0]        i_mem_fault,
    output logic      [15:0]       o_rdata,
    output logic                   o_selftest_enable,
    output srm_rate_t              o_local_out_rate [16],
    output srm_rate_t              o_backplane_in_rate [16],
    output srm_rate_t              o_backplane_out_rate [16]
);
    logic [1:0]  local_out_rate_field [16];
    logic [1:0]  backplane_in_rate_field [16];
    logic [1:0]  backplane_out_rate_field [16];
    logic        selftest_enable;
    logic [3:0]  start_bits;
    logic [3:0]  start_d;
    logic [15:0] next_rdata;
    logic [15:0] test_word;
    logic [13:0] lo_off;
    logic [13:0] bi_off;
    logic [13:0] bo_off;
    logic        hit_lo;
    logic        hit_bi;
    logic        hit_bo;
    logic        hit_mst;

    srm_test_if tif ();

    srm_test_engine u_engine (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .tif     (tif)
    );

    assign lo_off  = i_addr - `SRM_LOR_BASE;
    assign bi_off  = i_addr - `SRM_BIR_BASE;
    assign bo_off  = i_addr - `SRM_BOR_BASE;
    assign hit_lo  = lo_off < 14'(`SRM_NSTREAM);
    assign hit_bi  = bi_off < 14'(`SRM_NSTREAM);
    assign hit_bo  = bo_off < 14'(`SRM_NSTREAM);
    assign hit_mst = i_addr == `SRM_MST_ADDR;

    // Reserved bits are not stored, so a careless host write cannot leak into them
    genvar s;
    generate
        for (s = 0; s < 16; s++) begin : g_stream
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    local_out_rate_field[s]     <= `SRM_RATE_RESET;
                    backplane_in_rate_field[s]  <= `SRM_RATE_RESET;
                    backplane_out_rate_field[s] <= `SRM_RATE_RESET;
                end else if (i_wr) begin
                    // Stored regardless of fast mode
                    if (hit_lo && lo_off[3:0] == 4'(s)) local_out_rate_field[s] <= i_wdata[`SRM_RATE_FIELD];
                    if (hit_bi && bi_off[3:0] == 4'(s)) backplane_in_rate_field[s] <= i_wdata[`SRM_RATE_FIELD];
                    if (hit_bo && bo_off[3:0] == 4'(s)) backplane_out_rate_field[s] <= i_wdata[`SRM_RATE_FIELD];
                end
            end
            assign o_local_out_rate[s] = i_local_fast_mode
                ? ((4'(s) <= `SRM_FAST_LAST) ? SRM_RATE_32M : SRM_RATE_OFF)
                : srm_rate_t'({1'b0, local_out_rate_field[s]});
            assign o_backplane_in_rate[s] = i_backplane_fast_mode
                ? ((4'(s) <= `SRM_FAST_LAST) ? SRM_RATE_32M : SRM_RATE_OFF)
                : srm_rate_t'({1'b0, backplane_in_rate_field[s]});
            assign o_backplane_out_rate[s] = i_backplane_fast_mode
                ? ((4'(s) <= `SRM_FAST_LAST) ? SRM_RATE_32M : SRM_RATE_OFF)
                : srm_rate_t'({1'b0, backplane_out_rate_field[s]});
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            selftest_enable <= 1'b0;
            start_bits      <= 4'h0;
        end else if (i_wr && hit_mst) begin
            selftest_enable <= i_wdata[`SRM_ST_ENABLE_BIT];
            // Start bits in order backplane data, local data, bp conn, local conn
            // Start bits are stored so that they read back and feed the edge detector
            start_bits      <= {i_wdata[`SRM_ST_START_BD], i_wdata[`SRM_ST_START_LD],
                                i_wdata[`SRM_ST_START_BC], i_wdata[`SRM_ST_START_LC]};
        end
    end

    // Edge detect; start bits still set by the write that sets the enable count as a rising edge
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            start_d <= 4'h0;
        end else begin
            start_d <= start_bits & {4{selftest_enable}};
        end
    end

    assign tif.enable       = {4{selftest_enable}};
    assign tif.start        = start_bits & ~start_d & {4{selftest_enable}};
    assign tif.fault        = i_mem_fault;
    assign o_selftest_enable = selftest_enable;

    always_comb begin
        test_word = {3'h0, selftest_enable,
                     start_bits[3], tif.done[3], tif.pass[3],
                     start_bits[2], tif.done[2], tif.pass[2],
                     start_bits[1], tif.done[1], tif.pass[1],
                     start_bits[0], tif.done[0], tif.pass[0]};
    end

    always_comb begin
        next_rdata = 16'h0000;
        if (hit_lo) begin
            next_rdata = {14'h0000, local_out_rate_field[lo_off[3:0]]};
        end else if (hit_bi) begin
            next_rdata = {14'h0000, backplane_in_rate_field[bi_off[3:0]]};
        end else if (hit_bo) begin
            next_rdata = {14'h0000, backplane_out_rate_field[bo_off[3:0]]};
        end else if (hit_mst) begin
            next_rdata = test_word;
        end else if (i_addr == `SRM_ID_ADDR) begin
            next_rdata = {8'h00, REV_CODE, 1'b0, DEV_CODE};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    AST_FAST_LOW: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_local_fast_mode |-> o_local_out_rate[0] == SRM_RATE_32M && o_local_out_rate[15] == SRM_RATE_OFF)
        else $error("local fast mode mapping wrong");
    AST_BPIN_FAST: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_backplane_fast_mode |-> o_backplane_in_rate[7] == SRM_RATE_32M && o_backplane_in_rate[8] == SRM_RATE_OFF)
        else $error("backplane input fast mapping wrong");
    AST_BPOUT_FAST: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_backplane_fast_mode |-> o_backplane_out_rate[3] == SRM_RATE_32M && o_backplane_out_rate[12] == SRM_RATE_OFF)
        else $error("backplane output fast mapping wrong");
    AST_RATE_WRITE: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_wr && i_addr == `SRM_LOR_BASE && !i_local_fast_mode ##1 !i_local_fast_mode
        |-> o_local_out_rate[0] == srm_rate_t'({1'b0, $past(i_wdata[`SRM_RATE_FIELD])}))
        else $error("local rate write not applied");
    AST_BPIN_RATE: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_wr && i_addr == `SRM_BIR_BASE + 14'h0005 && !i_backplane_fast_mode ##1 !i_backplane_fast_mode
        |-> o_backplane_in_rate[5] == srm_rate_t'({1'b0, $past(i_wdata[`SRM_RATE_FIELD])}))
        else $error("backplane input rate write not applied");
    AST_BPOUT_RATE: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_wr && i_addr == `SRM_BOR_BASE + 14'h0009 && !i_backplane_fast_mode ##1 !i_backplane_fast_mode
        |-> o_backplane_out_rate[9] == srm_rate_t'({1'b0, $past(i_wdata[`SRM_RATE_FIELD])}))
        else $error("backplane output rate write not applied");
    AST_KEEP_RATE: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(i_local_fast_mode) && !i_wr |=> $stable(local_out_rate_field[2]))
        else $error("fast mode disturbed stored rate");
    AST_ENABLE: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_wr && hit_mst |=> o_selftest_enable == $past(i_wdata[`SRM_ST_ENABLE_BIT]))
        else $error("test enable not taken");
    AST_START_RISE: assert property (@(posedge i_mclk) disable iff (i_reset)
        tif.start[2] |-> !$past(start_bits[2] && selftest_enable))
        else $error("start without a rising start bit");
    AST_DONE_HOLD: assert property (@(posedge i_mclk) disable iff (i_reset)
        tif.done[3] && selftest_enable && !tif.start[3] |=> tif.done[3])
        else $error("done dropped without restart or disable");
    AST_PASS_HOLD: assert property (@(posedge i_mclk) disable iff (i_reset)
        tif.done[2] && selftest_enable && !tif.start[2] |=> $stable(tif.pass[2]))
        else $error("pass changed while test complete");
    AST_RESET_LOW: assert property (@(posedge i_mclk)
        $past(i_reset) |-> tif.done == 4'h0 && tif.pass == 4'h0 && o_rdata == 16'h0000)
        else $error("status not low after reset");
    AST_START_EDGE: assert property (@(posedge i_mclk) disable iff (i_reset)
        tif.start[3] |=> !tif.start[3])
        else $error("start not a single pulse");
    AST_DONE_TIME: assert property (@(posedge i_mclk) disable iff (i_reset)
        tif.start[0] ##1 (selftest_enable && !tif.start[0])[*8] |-> !tif.done[0])
        else $error("done raised too early");
    AST_NO_TEST_OFF: assert property (@(posedge i_mclk) disable iff (i_reset)
        !selftest_enable ##1 !selftest_enable |-> tif.done == 4'h0 && tif.pass == 4'h0)
        else $error("status not cleared while disabled");
    AST_PASS_DONE: assert property (@(posedge i_mclk) disable iff (i_reset)
        tif.pass[1] |-> tif.done[1])
        else $error("pass without completion");
    AST_ID_READ: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_rd && i_addr == `SRM_ID_ADDR |=> o_rdata == {8'h00, REV_CODE, 1'b0, DEV_CODE})
        else $error("identity read wrong");

    COV_FAST_LOCAL: cover property (@(posedge i_mclk) disable iff (i_reset) $rose(i_local_fast_mode));
    COV_TEST_DONE:  cover property (@(posedge i_mclk) disable iff (i_reset) $rose(tif.done[3]));
    COV_TEST_PASS:  cover property (@(posedge i_mclk) disable iff (i_reset) $rose(tif.pass[0]));
    COV_ID_READ:    cover property (@(posedge i_mclk) disable iff (i_reset) i_rd && i_addr == `SRM_ID_ADDR);
    COV_FAST_BP:    cover property (@(posedge i_mclk) disable iff (i_reset) $rose(i_backplane_fast_mode));
endmodule

// ### sim/srm_host_model.sv
// Host processor model on the parallel register port of the rate and self-test bank.
// Assumes one-cycle strobes, sampled at the rising edge of the shared clock.
`timescale 1ns/10ps
module srm_host_model (
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_rdata,
    output logic      [13:0] o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_wdata
);
    initial begin
        o_addr  = 14'h0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h0000;
    end
    // Callers keep reserved bits at zero; a test launch is 1000h, then 1000h plus starts
    task automatic write_word(input logic [13:0] a, input logic [15:0] v);
        @(posedge i_mclk);
        o_addr  <= a;
        o_wdata <= v;
        o_wr    <= 1'b1;
        @(posedge i_mclk);
        o_wr    <= 1'b0;
        o_wdata <= ~v;  // Released data must not look like the last word
    endtask
    // Completion is only learned by polling the status word
    task automatic read_word(input logic [13:0] a, output logic [15:0] v);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_mclk);
        o_rd   <= 1'b0;
        #1;
        v = i_rdata;
    endtask
endmodule

// ### sim/stream_rate_and_memory_selftest_regs_bench.sv
// Self-checking bench for the rate and self-test register bank.
// Assumes the host model drives the register port; fast-mode and fault hooks come from here.
`timescale 1ns/10ps
`include "srm_defs.svh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module stream_rate_and_memory_selftest_regs_bench
    import srm_pkg::*;
;
    localparam logic [3:0] REV = 4'h3;  // Arbitrary value
    localparam logic [2:0] DEV = 3'h6;  // Arbitrary value
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        lfast = 1'b0;
    logic        bfast = 1'b0;
    logic [3:0]  fault = 4'h0;
    logic [13:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        st_en;
    logic [15:0] d;
    srm_rate_t   lo_rate [16];
    srm_rate_t   bi_rate [16];
    srm_rate_t   bo_rate [16];
    int          fail_count   = 0;
    int          total_checks = 0;

    always #12.5 clk = ~clk;

    srm_host_model host_u (.i_mclk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    srm_regs #(.REV_CODE(REV), .DEV_CODE(DEV)) dut_u (
        .i_mclk(clk), .i_reset(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .i_local_fast_mode(lfast), .i_backplane_fast_mode(bfast), .i_mem_fault(fault),
        .o_rdata(rdata), .o_selftest_enable(st_en), .o_local_out_rate(lo_rate),
        .o_backplane_in_rate(bi_rate), .o_backplane_out_rate(bo_rate));

    function automatic srm_rate_t exp_rate(input logic [1:0] f, input logic fast, input int n);
        if (!fast)
            return srm_rate_t'({1'b0, f});
        return (n < 8) ? SRM_RATE_32M : SRM_RATE_OFF;
    endfunction

    // Port p stream n holds field (n + p) mod 4, so every code appears on every port
    // Fast-mode inputs change on the rising edge; the rate outputs are settled 1 ns later
    task automatic check_rates(input logic lf, input logic bf);
        @(posedge clk);
        lfast <= lf;
        bfast <= bf;
        #1;
        for (int n = 0; n < 16; n++) begin
            `CHECK(lo_rate[n], exp_rate(2'(n), lfast, n))
            `CHECK(bi_rate[n], exp_rate(2'(n + 1), bfast, n))
            `CHECK(bo_rate[n], exp_rate(2'(n + 2), bfast, n))
        end
    endtask

    // Enable, launch all four memories, poll until every done bit is up
    task automatic run_selftest(input logic [3:0] flt, input logic [15:0] want);
        @(posedge clk);
        fault <= flt;
        host_u.write_word(`SRM_MST_ADDR, 16'h1000);
        #1;
        `CHECK(st_en, 1'b1)
        host_u.write_word(`SRM_MST_ADDR, 16'h1924);
        host_u.read_word(`SRM_MST_ADDR, d);
        `CHECK(d, 16'h1924)
        for (int i = 0; i < 800 && (d & 16'h0492) != 16'h0492; i++)
            host_u.read_word(`SRM_MST_ADDR, d);
        `CHECK(d, want)
    endtask

    task automatic complete_run();
        $display("Checks: %0d, mismatches: %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host_u.read_word(`SRM_MST_ADDR, d);
        `CHECK(d, 16'h0000)
        `CHECK(lo_rate[15], SRM_RATE_2M)
        for (int n = 0; n < 16; n++) begin
            host_u.write_word(`SRM_LOR_BASE + 14'(n), {14'h0000, 2'(n)});
            host_u.write_word(`SRM_BIR_BASE + 14'(n), {14'h0000, 2'(n + 1)});
            host_u.write_word(`SRM_BOR_BASE + 14'(n), {14'h0000, 2'(n + 2)});
        end
        for (int n = 0; n < 16; n++) begin
            host_u.read_word(`SRM_LOR_BASE + 14'(n), d);
            `CHECK(d, {14'h0000, 2'(n)})
            host_u.read_word(`SRM_BIR_BASE + 14'(n), d);
            `CHECK(d, {14'h0000, 2'(n + 1)})
            host_u.read_word(`SRM_BOR_BASE + 14'(n), d);
            `CHECK(d, {14'h0000, 2'(n + 2)})
        end
        check_rates(1'b0, 1'b0);
        check_rates(1'b1, 1'b0);
        check_rates(1'b1, 1'b1);
        check_rates(1'b0, 1'b0);
        // Identity ignores writes; unmapped space reads as zero
        host_u.write_word(`SRM_ID_ADDR, 16'hFFFF);
        host_u.read_word(`SRM_ID_ADDR, d);
        `CHECK(d, {8'h00, REV, 1'b0, DEV})
        host_u.read_word(14'h0200, d);
        `CHECK(d, 16'h0000)
        // Faults on local data and local connection memories only
        run_selftest(4'h5, 16'h1FBE);
        // Same start bits again are no rising edge: results must hold
        host_u.write_word(`SRM_MST_ADDR, 16'h1924);
        repeat (3) host_u.read_word(`SRM_MST_ADDR, d);
        `CHECK(d, 16'h1FBE)
        host_u.write_word(`SRM_MST_ADDR, 16'h0000);
        host_u.read_word(`SRM_MST_ADDR, d);
        `CHECK(d, 16'h0000)
        `CHECK(st_en, 1'b0)
        // Relaunch after disable, now with both backplane memories failing
        run_selftest(4'hA, 16'h1DF7);
        // Reset after the completed run clears status, enable and stored rates
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host_u.read_word(`SRM_MST_ADDR, d);
        `CHECK(d, 16'h0000)
        `CHECK(st_en, 1'b0)
        `CHECK(lo_rate[3], SRM_RATE_2M)
        host_u.read_word(`SRM_BOR_BASE + 14'h0003, d);
        `CHECK(d, 16'h0000)
        complete_run();
    end
endmodule
